// file: rtl/psd_port_select.sv
`include "psd_params.svh"
`default_nettype none
module psd_port_select #(
    parameter int DEBOUNCE_CYC = `PSD_DEBOUNCE_CYC,
    parameter int PUMP_CYC = `PSD_PUMP_CYC,
    parameter int FLTHOLD_CYC = `PSD_FLTHOLD_CYC,
    parameter int TOGGLE_CYC = `PSD_TOGGLE_CYC
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [2:0] port_select_hi,
    input wire logic [2:0] port_select_lo,
    input wire logic line_fault,
    input wire logic esd_event,
    input wire logic vbus_high,
    input wire logic vbus_above_min,
    input wire logic vbus_in_window,
    input wire logic ibus_ok,
    input wire logic cdp_active,
    input wire logic cdp_done,
    output logic [4:0] select_code,
    output logic vbus_enable,
    output logic vbus_discharge,
    output logic softstart_reset,
    output logic switch_pos_close,
    output logic switch_neg_close,
    output logic switch_on_done,
    output logic pulldown_en,
    output logic cdp_enable,
    output logic status_out,
    output logic fault_out_low
);
    import psd_pkg::*;

    // ----------------------------------------
    // input sync and level classify
    // ----------------------------------------
    logic [2:0] hi_s1_r, hi_s2_r, lo_s1_r, lo_s2_r;
    always_ff @(posedge clk) begin
        if (reset) begin
            hi_s1_r <= 3'h0;
            hi_s2_r <= 3'h0;
            lo_s1_r <= 3'h0;
            lo_s2_r <= 3'h0;
        end else begin
            hi_s1_r <= port_select_hi;
            hi_s2_r <= hi_s1_r;
            lo_s1_r <= port_select_lo;
            lo_s2_r <= lo_s1_r;
        end
    end

    function automatic psd_lvl_e classify(input logic hi, input logic lo);
        if (hi && !lo) return PSD_LVL_HIGH;
        if (lo && !hi) return PSD_LVL_LOW;
        return PSD_LVL_OPEN;
    endfunction : classify

    function automatic logic [4:0] trit(input psd_lvl_e l);
        case (l)
            PSD_LVL_LOW: return 5'h00;
            PSD_LVL_OPEN: return 5'h01;
            default: return 5'h02;
        endcase
    endfunction : trit

    psd_lvl_e stab [3];
    for (genvar i = 0; i < 3; i++) begin : g_db
        psd_debounce #(.DEBOUNCE_CYC(DEBOUNCE_CYC)) u_db (
            .clk(clk),
            .reset(reset),
            .raw_lvl(classify(hi_s2_r[i], lo_s2_r[i])),
            .stable_lvl(stab[i])
        );
    end

    // code = a + 3b + 9c
    psd_code_t code;
    assign code = trit(stab[0]) + 5'(3 * trit(stab[1])) + 5'(9 * trit(stab[2]));

    // ----------------------------------------
    // state table
    // ----------------------------------------
    psd_vbus_e vb;
    psd_status_e st;
    logic close_c, pd_c, cdp_c, brst_c;
    always_comb begin
        vb = PSD_VB_ON;
        st = PSD_ST_TOGGLE;
        close_c = 1'b0;
        pd_c = 1'b0;
        cdp_c = 1'b0;
        brst_c = 1'b0;
        case (code)
            5'd0: begin
                close_c = 1'b1;
                cdp_c = 1'b1;
                st = PSD_ST_CDP;
            end
            5'd1: begin
                close_c = cdp_done;
                pd_c = !cdp_done;
                cdp_c = 1'b1;
                st = PSD_ST_CDP;
            end
            // engine still runs so status can report the negotiation outcome
            5'd2: begin
                close_c = 1'b1;
                cdp_c = 1'b1;
                st = PSD_ST_CDP_OK;
            end
            5'd3, 5'd18: begin
                close_c = code == 5'd3;
                pd_c = 1'b1;
                vb = PSD_VB_OFF;
                st = PSD_ST_VOLT;
            end
            5'd4, 5'd19: begin
                close_c = code == 5'd4;
                pd_c = 1'b1;
                st = PSD_ST_CURR;
            end
            5'd5, 5'd20: begin
                close_c = code == 5'd5;
                pd_c = 1'b1;
                vb = PSD_VB_DISCHARGE;
                st = PSD_ST_DISCH;
                brst_c = 1'b1;
            end
            5'd9: begin
                close_c = 1'b1;
                vb = PSD_VB_OFF;
                st = PSD_ST_VOLT;
            end
            5'd10: begin
                close_c = 1'b1;
                st = PSD_ST_CURR;
            end
            5'd11, 5'd14: begin
                close_c = code == 5'd11;
                vb = PSD_VB_DISCHARGE;
                st = PSD_ST_DISCH;
                brst_c = 1'b1;
            end
            5'd12: begin
                vb = PSD_VB_OFF;
                st = PSD_ST_VOLT;
            end
            5'd13, 5'd21, 5'd22, 5'd24, 5'd25, 5'd26: st = PSD_ST_CURR;
            default: st = PSD_ST_TOGGLE;
        endcase
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    logic prot;
    assign prot = line_fault | esd_event;
    logic [15:0] pump_r;
    logic [23:0] tog_r;
    logic [23:0] flt_r;
    logic brst_prev_r;

    always_ff @(posedge clk) begin
        if (reset) begin
            select_code <= `PSD_RESET_CODE;
            vbus_enable <= 1'b1;
            vbus_discharge <= 1'b0;
            softstart_reset <= 1'b0;
            pulldown_en <= 1'b0;
            cdp_enable <= 1'b0;
        end else begin
            select_code <= code;
            vbus_enable <= vb == PSD_VB_ON;
            vbus_discharge <= vb == PSD_VB_DISCHARGE;
            softstart_reset <= vb != PSD_VB_ON;
            pulldown_en <= pd_c;
            cdp_enable <= cdp_c;
        end
    end

    // switches and charge pump delay
    always_ff @(posedge clk) begin
        if (reset) begin
            switch_pos_close <= 1'b0;
            switch_neg_close <= 1'b0;
            switch_on_done <= 1'b0;
            pump_r <= 16'h0000;
        end else begin
            switch_pos_close <= close_c && !prot;
            switch_neg_close <= close_c && !prot;
            if (!close_c || prot) begin
                pump_r <= 16'h0000;
                switch_on_done <= 1'b0;
            end else if (pump_r < 16'(PUMP_CYC - 1)) begin
                pump_r <= pump_r + 16'h0001;
            end else begin
                switch_on_done <= 1'b1;
            end
        end
    end

    // status output
    always_ff @(posedge clk) begin
        if (reset) begin
            tog_r <= 24'h000000;
            status_out <= 1'b0;
        end else begin
            tog_r <= (tog_r >= 24'(TOGGLE_CYC - 1)) ? 24'h000000 : tog_r + 24'h000001;
            case (st)
                PSD_ST_CDP: status_out <= cdp_active;
                PSD_ST_CDP_OK: status_out <= cdp_done;
                PSD_ST_VOLT: status_out <= vbus_above_min;
                PSD_ST_CURR: status_out <= ibus_ok;
                PSD_ST_DISCH: status_out <= !vbus_above_min;
                default: if (tog_r == 24'h000000) status_out <= !status_out;
            endcase
        end
    end

    // fault output, driven high while a fault is flagged
    always_ff @(posedge clk) begin
        if (reset) begin
            flt_r <= 24'h000000;
            brst_prev_r <= 1'b0;
            fault_out_low <= 1'b0;
        end else begin
            brst_prev_r <= brst_c;
            if (brst_prev_r && !brst_c && vbus_above_min)
                flt_r <= 24'(FLTHOLD_CYC);
            else if (flt_r != 24'h000000)
                flt_r <= flt_r - 24'h000001;
            fault_out_low <= (vb == PSD_VB_ON && !vbus_in_window)
                || (brst_c && vbus_high) || (flt_r != 24'h000000);
        end
    end
endmodule : psd_port_select
`default_nettype wire

// file: rtl/psd_params.svh
`ifndef PSD_PARAMS_SVH
`define PSD_PARAMS_SVH
`define PSD_CLK_HZ 20000000
`define PSD_DEBOUNCE_US 1500
`define PSD_DEBOUNCE_CYC ((`PSD_DEBOUNCE_US * (`PSD_CLK_HZ / 1000000)))
`define PSD_PUMP_US 1000
`define PSD_PUMP_CYC ((`PSD_PUMP_US * (`PSD_CLK_HZ / 1000000)))
`define PSD_FLTHOLD_US 4200
`define PSD_FLTHOLD_CYC ((`PSD_FLTHOLD_US * (`PSD_CLK_HZ / 1000000)))
`define PSD_TOGGLE_CYC 10000
`define PSD_RESET_CODE 5'h0d
`endif

// file: rtl/psd_pkg.sv
`default_nettype none
package psd_pkg;
    typedef enum logic [1:0] {PSD_LVL_LOW, PSD_LVL_HIGH, PSD_LVL_OPEN} psd_lvl_e;
    typedef enum logic [1:0] {PSD_VB_OFF, PSD_VB_ON, PSD_VB_DISCHARGE} psd_vbus_e;
    typedef enum logic [2:0] {
        PSD_ST_CDP, PSD_ST_CDP_OK, PSD_ST_VOLT, PSD_ST_CURR, PSD_ST_DISCH, PSD_ST_TOGGLE
    } psd_status_e;
    typedef logic [4:0] psd_code_t;
endpackage : psd_pkg
`default_nettype wire

// file: rtl/psd_debounce.sv
`include "psd_params.svh"
`default_nettype none
module psd_debounce #(
    parameter int DEBOUNCE_CYC = `PSD_DEBOUNCE_CYC
) (
    input wire logic clk,
    input wire logic reset,
    input wire psd_pkg::psd_lvl_e raw_lvl,
    output psd_pkg::psd_lvl_e stable_lvl
);
    import psd_pkg::*;
    psd_lvl_e cand_r;
    logic [15:0] cnt_r;
    psd_lvl_e stable_r;
    assign stable_lvl = stable_r;
    // ----------------------------------------
    // hold-time filter
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (reset) begin
            cand_r <= PSD_LVL_OPEN;
            cnt_r <= 16'h0000;
            stable_r <= PSD_LVL_OPEN;
        end else if (raw_lvl != cand_r) begin
            cand_r <= raw_lvl;
            cnt_r <= 16'h0000;
        end else if (cnt_r < 16'(DEBOUNCE_CYC - 1)) begin
            cnt_r <= cnt_r + 16'h0001;
        end else begin
            stable_r <= cand_r;
        end
    end
endmodule : psd_debounce
`default_nettype wire

// file: tb/psd_host_model.sv
`default_nettype none
module psd_host_model (
    input wire logic [4:0] want_code,
    output logic [2:0] port_select_hi,
    output logic [2:0] port_select_lo
);
    timeunit 1ns;
    timeprecision 1ns;
    always_comb begin
        int rest;
        rest = int'(want_code);
        for (int i = 0; i < 3; i++) begin
            port_select_hi[i] = (rest % 3) == 2;
            port_select_lo[i] = (rest % 3) == 0;
            rest = rest / 3;
        end
    end
endmodule : psd_host_model
`default_nettype wire

// file: tb/psd_port_select_monitor.sv
`default_nettype none
module psd_port_select_monitor #(
    parameter int DEBOUNCE_CYC = 8
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [2:0] port_select_hi,
    input wire logic [2:0] port_select_lo,
    input wire logic line_fault,
    input wire logic esd_event,
    input wire logic vbus_high,
    input wire logic [4:0] select_code,
    input wire logic vbus_enable,
    input wire logic vbus_discharge,
    input wire logic softstart_reset,
    input wire logic switch_pos_close,
    input wire logic switch_neg_close,
    input wire logic switch_on_done
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);
    int quiet_r;
    // cycles the raw pins held still, saturating
    always_ff @(posedge clk) begin
        if (reset || $changed({port_select_hi, port_select_lo})) begin
            quiet_r <= 0;
        end else if (quiet_r < DEBOUNCE_CYC) begin
            quiet_r <= quiet_r + 1;
        end
    end
    sequence s_close_rise;
        $rose(switch_pos_close);
    endsequence
    // pump length of 8 as the bench builds it
    sequence s_close_held;
        switch_pos_close [*8];
    endsequence
    chk_code_range: assert property (select_code <= 5'h1a)
        else $error("select code out of range");
    chk_debounce_hold: assert property ($changed(select_code) |-> quiet_r >= DEBOUNCE_CYC)
        else $error("code changed before pins settled");
    chk_vbus_excl: assert property (!(vbus_enable && vbus_discharge))
        else $error("regulator on while discharging");
    chk_pair_equal: assert property (switch_pos_close == switch_neg_close)
        else $error("line switches disagree");
    chk_fault_open: assert property (line_fault || esd_event |=> !switch_pos_close)
        else $error("switch closed during fault");
    chk_reset_state: assert property (select_code == 5'h0d |->
        vbus_enable && !switch_pos_close)
        else $error("reset state outputs wrong");
    chk_pump_wait: assert property (s_close_rise |-> (!switch_on_done) [*6])
        else $error("switch done too early");
    chk_pump_done: assert property (s_close_rise ##0 s_close_held |->
        ##[0:3] switch_on_done)
        else $error("switch done too late");
    chk_ss_follow: assert property (softstart_reset == !vbus_enable)
        else $error("soft start reset wrong");
endmodule : psd_port_select_monitor
bind psd_port_select psd_port_select_monitor #(.DEBOUNCE_CYC(DEBOUNCE_CYC)) mon_i (
    .clk, .reset, .port_select_hi, .port_select_lo, .line_fault, .esd_event, .vbus_high,
    .select_code, .vbus_enable, .vbus_discharge, .softstart_reset, .switch_pos_close,
    .switch_neg_close, .switch_on_done
);
`default_nettype wire

// file: tb/tb.sv
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [4:0] want_code = 5'h0d;
    logic line_fault = 1'b0, esd_event = 1'b0, vbus_high = 1'b0, vbus_above_min = 1'b0;
    logic vbus_in_window = 1'b1, ibus_ok = 1'b0, cdp_active = 1'b0, cdp_done = 1'b0;
    logic [2:0] port_select_hi, port_select_lo;
    logic [4:0] select_code;
    logic vbus_enable, vbus_discharge, softstart_reset, switch_pos_close, switch_neg_close;
    logic switch_on_done, pulldown_en, cdp_enable, status_out, fault_out_low, prev;
    int num_errors = 0, n_checks = 0, cyc = 0, flips;
    // per code: vbus on, discharge, closed, pull-downs
    localparam logic [55:0] EXP_MAP = 56'h806a2888_7b3a9a;
    psd_host_model psd_host_model_i (.want_code, .port_select_hi, .port_select_lo);
    psd_port_select #(.DEBOUNCE_CYC(8), .PUMP_CYC(8), .FLTHOLD_CYC(16), .TOGGLE_CYC(4))
        psd_port_select_i (.clk, .reset, .port_select_hi, .port_select_lo, .line_fault,
        .esd_event, .vbus_high, .vbus_above_min, .vbus_in_window, .ibus_ok, .cdp_active,
        .cdp_done, .select_code, .vbus_enable, .vbus_discharge, .softstart_reset,
        .switch_pos_close, .switch_neg_close, .switch_on_done, .pulldown_en, .cdp_enable,
        .status_out, .fault_out_low);
    initial begin
        forever #25 clk = ~clk;
    end
    task automatic chk(input string what, input logic [4:0] exp, input logic [4:0] got);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %s exp %h got %h", what, exp, got);
        end
    endtask : chk
    // drive at falling edge, then let pump settle
    task automatic go(input logic [4:0] c);
        @(negedge clk);
        want_code = c;
        for (int i = 0; i < 40 && select_code !== c; i++) begin
            @(negedge clk);
        end
        repeat (12) @(negedge clk);
    endtask : go
    task automatic finish_test();
        if (num_errors == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : finish_test
    always @(posedge clk) begin
        cyc++;
        if (cyc == 4000) begin
            num_errors++;
            finish_test();
        end
    end
    initial begin
        repeat (4) @(negedge clk);
        reset = 1'b0;
        chk("code", 5'h0d, select_code);
        for (int c = 0; c < 14; c++) begin
            go(5'(c));
            chk("code", 5'(c), select_code);
            chk("map", 5'(EXP_MAP[c*4 +: 4]),
                {vbus_enable, vbus_discharge, switch_pos_close, pulldown_en});
            chk("neg", 5'(EXP_MAP[c*4+1]), switch_neg_close);
            chk("done", 5'(EXP_MAP[c*4+1]), switch_on_done);
            chk("ss", 5'(!EXP_MAP[c*4+3]), softstart_reset);
            chk("cdp_en", 5'(c <= 2), cdp_enable);
        end
        // short pulse must not reach the decoder
        want_code = 5'h04;
        repeat (4) @(negedge clk);
        want_code = 5'h0d;
        repeat (20) @(negedge clk);
        chk("glitch", 5'h0d, select_code);
        go(5'h0a);
        for (int k = 0; k < 3; k++) begin
            line_fault = (k == 0);
            esd_event = (k == 1);
            repeat (3) @(negedge clk);
            chk("fault", 5'(k == 2), switch_pos_close);
        end
        for (int k = 0; k < 2; k++) begin
            go(k ? 5'h04 : 5'h0c);
            for (int v = 0; v < 2; v++) begin
                vbus_above_min = v[0];
                ibus_ok = !v[0];
                repeat (3) @(negedge clk);
                chk("status", 5'(k ? 1 - v : v), status_out);
            end
        end
        go(5'h02);
        cdp_done = 1'b1;
        repeat (3) @(negedge clk);
        chk("cdp", 5'h01, status_out);
        go(5'h01);
        chk("cdp1", 5'h02, {switch_pos_close, pulldown_en});
        cdp_active = 1'b1;
        repeat (3) @(negedge clk);
        chk("cdp_act", 5'h01, status_out);
        cdp_active = 1'b0;
        cdp_done = 1'b0;
        go(5'h07);
        flips = 0;
        for (int i = 0; i < 16; i++) begin
            prev = status_out;
            @(negedge clk);
            flips += int'(prev !== status_out);
        end
        chk("toggle", 5'h04, 5'(flips));
        vbus_high = 1'b1;
        go(5'h05);
        chk("busrst", 5'h01, fault_out_low);
        chk("disch", 5'h00, status_out);
        vbus_high = 1'b0;
        go(5'h0d);
        chk("hold", 5'h01, fault_out_low);
        repeat (20) @(negedge clk);
        chk("free", 5'h00, fault_out_low);
        vbus_in_window = 1'b0;
        repeat (3) @(negedge clk);
        chk("window", 5'h01, fault_out_low);
        finish_test();
    end
endmodule : tb
`default_nettype wire
